// >>> src/vsp_sync_processor.sv
// Monitor sync processor: polarity, detection, separation, reshaping, pseudo syncs.
// Overview of operation
// - Pulses shorter than one clock period on any input are ignored.
// - Horizontal and vertical syncs are delivered downstream with negative polarity.
// - Separate vertical low time above 1024 cycles inverts it, else passes through.
// - Both polarity correctors assume negative input polarity after reset.
// - Pulses above 16 cycles are long; eight long lows invert, eight long highs pass.
// - Inputs count active only when periods and low widths lie within limits; composite horizontal low widths are not checked.
// - Free-running pseudo syncs have periods of 31360 and 35 cycles.
// - Pseudo syncs drive the output pins whenever processed syncs are not chosen.
// - Processed syncs reach the outputs only when selected with both flags set.
// - Composite low pulses up to 16 cycles advance the line counter.
// - Longer composite lows capture lines per frame and clear the counter.
// - Composite high pulses above 16 cycles signal end of vertical sync.
// - On line match, separation arms; at next fall vertical drops and emulated horizontal pulses start.
// - After end of vertical, vertical goes high and composite drives horizontal.
// - Vertical out falls with input vertical and rises at sixth horizontal fall.
// - Separate horizontal out equals horizontal input made negative.
// - One line interrupt pulse per frame at the programmed line number.
// - Source select: 00 separate, 01 composite on horizontal, 1x composite input.
// - Processed select clears when either active flag is low and at reset.
`timescale 1ns/1ps
module vsp_sync_processor #(
  parameter logic [15:0] FREE_V_PER = vsp_pkg::FREE_V_PER,
  parameter logic [15:0] V_PER_MIN  = vsp_pkg::V_PER_MIN,
  parameter logic [15:0] V_PER_MAX  = vsp_pkg::V_PER_MAX
) (
  input  wire logic        I_REF_CLK,
  input  wire logic        I_NRST,
  input  wire logic        I_HSYNC,
  input  wire logic        I_VSYNC,
  input  wire logic        I_CSYNC,
  input  wire logic [1:0]  I_SYNC_SOURCE_SELECT,
  input  wire logic        I_INSERT_DISABLE,
  input  wire logic        I_PROCESSED_SYNC_SET,
  input  wire logic        I_PROCESSED_SYNC_CLR,
  input  wire logic        I_LINE_IRQ_ENABLE,
  input  wire logic [6:0]  I_LINE_IRQ_NUMBER,
  output logic             O_HORIZ_SYNC_OUT,
  output logic             O_VERT_SYNC_OUT,
  output logic             O_HORIZ_ACTIVE_FLAG,
  output logic             O_VERT_ACTIVE_FLAG,
  output logic             O_PROCESSED_SYNC_SELECT,
  output logic             O_HORIZ_POL,
  output logic             O_VERT_POL,
  output logic [11:0]      O_LINES_PER_FRAME,
  output logic             O_LINE_IRQ
);
  // ==========================================================================
  // Filtered inputs and source routing.
  vsp_flt_if flt ();
  vsp_filter u_filter (
    .i_clk  (I_REF_CLK),
    .i_nrst (I_NRST),
    .i_raw  ({I_CSYNC, I_VSYNC, I_HSYNC}),
    .flt    (flt)
  );

  logic comp, hc, vin, hn, vn, vs, hfall, hrise, vsfall, lng_lo, lng_hi, lev, vev, fin;
  logic hc_d_r, hn_d_r, vn_d_r, vs_d_r, hpol_r, vpol_r, hpol_nxt, vpol_nxt;
  logic [4:0]  hlen_r, hlen_nxt;
  logic [3:0]  lrun_r, hrun_r, lrun_nxt, hrun_nxt;
  logic [10:0] vlow_r, vlow_nxt;

  assign comp   = (I_SYNC_SOURCE_SELECT != vsp_pkg::SRC_SEP);
  assign hc     = I_SYNC_SOURCE_SELECT[1] ? flt.lvl[vsp_pkg::IDX_C] : flt.lvl[vsp_pkg::IDX_H];
  assign vin    = flt.lvl[vsp_pkg::IDX_V];
  assign hn     = hc ^ hpol_r;
  assign vn     = vin ^ vpol_r;
  assign hfall  = hn_d_r & ~hn;
  assign hrise  = ~hn_d_r & hn;
  assign lng_lo = (hc != hc_d_r) & ~hc_d_r & (hlen_r > vsp_pkg::H_LONG_LIM);
  assign lng_hi = (hc != hc_d_r) & hc_d_r & (hlen_r > vsp_pkg::H_LONG_LIM);

  // ==========================================================================
  // Polarity correction for the horizontal/composite and vertical paths.
  always_comb begin
    hlen_nxt = (hc != hc_d_r) ? 5'h01 : ((hlen_r == 5'h1F) ? hlen_r : hlen_r + 5'h01);
    lrun_nxt = lrun_r;
    hrun_nxt = hrun_r;
    hpol_nxt = hpol_r;
    if (lng_lo) begin
      hrun_nxt = 4'h0;
      lrun_nxt = (lrun_r == vsp_pkg::POL_RUN) ? lrun_r : lrun_r + 4'h1;
      if (lrun_nxt == vsp_pkg::POL_RUN) hpol_nxt = 1'b1;
    end else if (lng_hi) begin
      lrun_nxt = 4'h0;
      hrun_nxt = (hrun_r == vsp_pkg::POL_RUN) ? hrun_r : hrun_r + 4'h1;
      if (hrun_nxt == vsp_pkg::POL_RUN) hpol_nxt = 1'b0;
    end
    vlow_nxt = vin ? 11'h000 : ((vlow_r == 11'h7FF) ? vlow_r : vlow_r + 11'h001);
    vpol_nxt = vpol_r;
    if (!vin && vlow_r > vsp_pkg::V_POL_LIM) vpol_nxt = 1'b1;
    else if (vin && vlow_r != 11'h000 && vlow_r <= vsp_pkg::V_POL_LIM) vpol_nxt = 1'b0;
  end

  // Registers the polarity state; negative polarity is assumed at reset.
  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      hc_d_r <= vsp_pkg::FLT_RST;
      hlen_r <= 5'h00;
      lrun_r <= 4'h0;
      hrun_r <= 4'h0;
      hpol_r <= vsp_pkg::POL_RST;
      vlow_r <= 11'h000;
      vpol_r <= vsp_pkg::POL_RST;
    end else begin
      hc_d_r <= hc;
      hlen_r <= hlen_nxt;
      lrun_r <= lrun_nxt;
      hrun_r <= hrun_nxt;
      hpol_r <= hpol_nxt;
      vlow_r <= vlow_nxt;
      vpol_r <= vpol_nxt;
    end
  end

  // ==========================================================================
  // Sync detection, line counting and composite separation.
  vsp_pkg::vsp_sep_t sep_r, sep_nxt;
  logic [7:0]  hw_r, hw_nxt, hper_r, hper_nxt, emu_r, emu_nxt;
  logic [4:0]  hlw_r, hlw_nxt;
  logic [15:0] vw_r, vw_nxt;
  logic [11:0] line_r, line_nxt, lpf_r, lpf_nxt;
  logic [2:0]  ecnt_r, ecnt_nxt;
  logic        hok_r, hok_nxt, vok_r, vok_nxt, hact_r, hact_nxt, vact_r, vact_nxt;
  logic        vsep_r, vsep_nxt, vout_r, vout_nxt, eq, emu_h, hsep;

  assign vs     = comp ? vsep_r : vn;
  assign vsfall = vs_d_r & ~vs;
  assign lev    = comp ? (hrise && hlen_r <= vsp_pkg::H_LONG_LIM) : hfall;
  assign vev    = comp ? (!hn && hlen_r == vsp_pkg::H_LONG_HIT) : vsfall;
  assign fin    = comp && hn && hlen_r == vsp_pkg::H_LONG_HIT;
  assign eq     = comp && lpf_r != 12'h000 && line_r == lpf_r;
  assign emu_h  = (emu_r >= {3'h0, hlw_r});
  assign hsep   = (sep_r == vsp_pkg::SEP_VLOW && !I_INSERT_DISABLE) ? emu_h : hn;

  always_comb begin
    hw_nxt   = hfall ? 8'h01 : ((hw_r == 8'hFF) ? hw_r : hw_r + 8'h01);
    hper_nxt = hfall ? hw_r : hper_r;
    hlw_nxt  = (hrise && hlen_r < vsp_pkg::H_LONG_LIM) ? hlen_r : hlw_r;
    hok_nxt  = hrise ? (comp || hlen_r < vsp_pkg::H_LONG_LIM) : hok_r;
    hact_nxt = hact_r;
    if (hw_r >= vsp_pkg::H_PER_LIM) hact_nxt = 1'b0;
    else if (hfall) hact_nxt = hok_r && (lpf_r != vsp_pkg::LPF_MAX || !vact_r);
    vw_nxt   = vsfall ? 16'h0001 : ((vw_r == 16'hFFFF) ? vw_r : vw_r + 16'h0001);
    vok_nxt  = (!vs_d_r && vs) ? (vw_r < {5'h00, vsp_pkg::V_POL_LIM}) : vok_r;
    vact_nxt = vact_r;
    if (vw_r >= V_PER_MAX) vact_nxt = 1'b0;
    else if (vsfall) vact_nxt = vok_r && vw_r > V_PER_MIN;
    line_nxt = line_r;
    lpf_nxt  = lpf_r;
    if (vev) begin
      lpf_nxt  = line_r;
      line_nxt = 12'h000;
    end else if (lev && line_r != vsp_pkg::LPF_MAX) begin
      line_nxt = line_r + 12'h001;
    end
    sep_nxt  = sep_r;
    vsep_nxt = vsep_r;
    emu_nxt  = (emu_r + 8'h01 >= hper_r) ? 8'h00 : emu_r + 8'h01;
    case (sep_r)
      vsp_pkg::SEP_PASS: begin
        if (eq) sep_nxt = vsp_pkg::SEP_ARMED;
      end
      vsp_pkg::SEP_ARMED: begin
        if (hfall) begin
          sep_nxt  = vsp_pkg::SEP_VLOW;
          vsep_nxt = 1'b0;
          emu_nxt  = 8'h01;
        end
      end
      vsp_pkg::SEP_VLOW: begin
        if (fin) begin
          sep_nxt  = vsp_pkg::SEP_PASS;
          vsep_nxt = 1'b1;
        end
      end
      default: begin
        sep_nxt  = vsp_pkg::SEP_PASS;
        vsep_nxt = 1'b1;
      end
    endcase
    if (!comp) begin
      sep_nxt  = vsp_pkg::SEP_PASS;
      vsep_nxt = 1'b1;
    end
    vout_nxt = vout_r;
    ecnt_nxt = ecnt_r;
    if (vsfall) begin
      vout_nxt = 1'b0;
      ecnt_nxt = 3'h0;
    end else if (!vout_r && hfall) begin
      ecnt_nxt = ecnt_r + 3'h1;
      if (ecnt_nxt == vsp_pkg::RESHAPE_N) vout_nxt = 1'b1;
    end
  end

  // Registers detection, counting, separation and reshaping state.
  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      hn_d_r <= vsp_pkg::FLT_RST;
      vn_d_r <= vsp_pkg::FLT_RST;
      vs_d_r <= vsp_pkg::FLT_RST;
      hw_r   <= 8'h00;
      hper_r <= 8'h00;
      hlw_r  <= 5'h00;
      hok_r  <= 1'b0;
      hact_r <= 1'b0;
      vw_r   <= 16'h0000;
      vok_r  <= 1'b0;
      vact_r <= 1'b0;
      line_r <= 12'h000;
      lpf_r  <= 12'h000;
      sep_r  <= vsp_pkg::SEP_PASS;
      vsep_r <= 1'b1;
      emu_r  <= 8'h00;
      vout_r <= 1'b1;
      ecnt_r <= 3'h0;
    end else begin
      hn_d_r <= hn;
      vn_d_r <= vn;
      vs_d_r <= vs;
      hw_r   <= hw_nxt;
      hper_r <= hper_nxt;
      hlw_r  <= hlw_nxt;
      hok_r  <= hok_nxt;
      hact_r <= hact_nxt;
      vw_r   <= vw_nxt;
      vok_r  <= vok_nxt;
      vact_r <= vact_nxt;
      line_r <= line_nxt;
      lpf_r  <= lpf_nxt;
      sep_r  <= sep_nxt;
      vsep_r <= vsep_nxt;
      emu_r  <= emu_nxt;
      vout_r <= vout_nxt;
      ecnt_r <= ecnt_nxt;
    end
  end

  // ==========================================================================
  // Free-running generator, output select, line interrupt and output flops.
  logic [5:0]  fh_r, fh_nxt;
  logic [15:0] fv_r, fv_nxt;
  logic        pss_r, pss_nxt, idone_r, idone_nxt, irq_nxt, free_h, free_v;

  assign free_h = (fh_r >= vsp_pkg::FREE_H_LOW);
  assign free_v = (fv_r >= vsp_pkg::FREE_V_LOW);

  always_comb begin
    fh_nxt = (fh_r == vsp_pkg::FREE_H_PER - 6'h01) ? 6'h00 : fh_r + 6'h01;
    fv_nxt = (fv_r == FREE_V_PER - 16'h0001) ? 16'h0000 : fv_r + 16'h0001;
    pss_nxt = pss_r;
    if (!(hact_r && vact_r)) pss_nxt = 1'b0;
    else if (I_PROCESSED_SYNC_SET) pss_nxt = 1'b1;
    else if (I_PROCESSED_SYNC_CLR) pss_nxt = 1'b0;
    idone_nxt = vev ? 1'b0 : idone_r;
    irq_nxt   = 1'b0;
    if (I_LINE_IRQ_ENABLE && (lev || vev) && !idone_r &&
        line_nxt == {5'h00, I_LINE_IRQ_NUMBER}) begin
      irq_nxt   = 1'b1;
      idone_nxt = 1'b1;
    end
  end

  // Registers the generator, the select bit and every output.
  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      fh_r                    <= 6'h00;
      fv_r                    <= 16'h0000;
      pss_r                   <= 1'b0;
      idone_r                 <= 1'b0;
      O_HORIZ_SYNC_OUT        <= 1'b1;
      O_VERT_SYNC_OUT         <= 1'b1;
      O_HORIZ_ACTIVE_FLAG     <= 1'b0;
      O_VERT_ACTIVE_FLAG      <= 1'b0;
      O_PROCESSED_SYNC_SELECT <= 1'b0;
      O_HORIZ_POL             <= 1'b0;
      O_VERT_POL              <= 1'b0;
      O_LINES_PER_FRAME       <= 12'h000;
      O_LINE_IRQ              <= 1'b0;
    end else begin
      fh_r                    <= fh_nxt;
      fv_r                    <= fv_nxt;
      pss_r                   <= pss_nxt;
      idone_r                 <= idone_nxt;
      O_HORIZ_SYNC_OUT        <= pss_r ? (comp ? hsep : hn) : free_h;
      O_VERT_SYNC_OUT         <= pss_r ? vout_r : free_v;
      O_HORIZ_ACTIVE_FLAG     <= hact_r;
      O_VERT_ACTIVE_FLAG      <= vact_r;
      O_PROCESSED_SYNC_SELECT <= pss_r;
      O_HORIZ_POL             <= hpol_r;
      O_VERT_POL              <= vpol_r;
      O_LINES_PER_FRAME       <= lpf_r;
      O_LINE_IRQ              <= irq_nxt;
    end
  end

  // ==========================================================================
  // Assertions.
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_NRST);

  sequence s_last_long_low;
    lrun_r == vsp_pkg::POL_RUN - 4'h1 && lng_lo;
  endsequence
  sequence s_last_long_high;
    hrun_r == vsp_pkg::POL_RUN - 4'h1 && lng_hi;
  endsequence
  sequence s_vlow_end;
    sep_r == vsp_pkg::SEP_VLOW && fin;
  endsequence

  property p_sel_drop;
    !(hact_r && vact_r) |=> !pss_r ##1 !O_PROCESSED_SYNC_SELECT;
  endproperty
  a_sel_drop: assert property (p_sel_drop) else $error("Select kept without flags.");
  property p_pol_inv;
    s_last_long_low |=> hpol_r ##1 O_HORIZ_POL;
  endproperty
  a_pol_inv: assert property (p_pol_inv) else $error("No inversion after long lows.");
  property p_pol_pass;
    s_last_long_high |=> !hpol_r;
  endproperty
  a_pol_pass: assert property (p_pol_pass) else $error("No pass after long highs.");
  property p_vpol;
    (!vin && vlow_r > vsp_pkg::V_POL_LIM) |=> vpol_r;
  endproperty
  a_vpol: assert property (p_vpol) else $error("Long vertical low not inverted.");
  property p_reshape;
    (!vout_r && ecnt_r == 3'h5 && hfall && !vsfall) |=> vout_r;
  endproperty
  a_reshape: assert property (p_reshape) else $error("Vertical out not ended.");
  property p_capture;
    vev |=> lpf_r == $past(line_r) && line_r == 12'h000;
  endproperty
  a_capture: assert property (p_capture) else $error("Lines per frame not taken.");
  property p_count;
    (lev && !vev && line_r != vsp_pkg::LPF_MAX) |=> line_r == $past(line_r) + 12'h001;
  endproperty
  a_count: assert property (p_count) else $error("Line counter not advanced.");
  property p_finish;
    s_vlow_end |=> sep_r == vsp_pkg::SEP_PASS && vsep_r;
  endproperty
  a_finish: assert property (p_finish) else $error("Vertical end not honoured.");
  property p_sep_drop;
    (comp && sep_r == vsp_pkg::SEP_ARMED && hfall) |=> !vsep_r;
  endproperty
  a_sep_drop: assert property (p_sep_drop) else $error("Vertical not dropped.");
  property p_free_out;
    !pss_r |=> O_HORIZ_SYNC_OUT == $past(free_h) && O_VERT_SYNC_OUT == $past(free_v);
  endproperty
  a_free_out: assert property (p_free_out) else $error("Pseudo syncs not driven.");
  property p_sep_h;
    (pss_r && !comp) |=> O_HORIZ_SYNC_OUT == $past(hn);
  endproperty
  a_sep_h: assert property (p_sep_h) else $error("Horizontal out not input.");
endmodule // vsp_sync_processor

// >>> shared/vsp_pkg.sv
// Constants and types shared by the sync processor design files.
package vsp_pkg;
  // ==========================================================================
  // Input indices and source select codes.
  localparam int         IDX_H     = 0;
  localparam int         IDX_V     = 1;
  localparam int         IDX_C     = 2;
  localparam logic [1:0] SRC_SEP   = 2'h0;  // Separate vertical and horizontal inputs.
  localparam logic       FLT_RST   = 1'h1;  // Filtered inputs idle high after reset.
  localparam logic       POL_RST   = 1'h0;  // Negative input polarity assumed at reset.

  // ==========================================================================
  // Pulse width and period limits, in bus clock cycles.
  localparam logic [4:0]  H_LONG_LIM  = 5'h10;   // 16 cycles: long pulse / horizontal limit.
  localparam logic [4:0]  H_LONG_HIT  = 5'h11;   // First cycle beyond the limit.
  localparam logic [3:0]  POL_RUN     = 4'h8;    // Consecutive long pulses to decide.
  localparam logic [10:0] V_POL_LIM   = 11'h400; // 1024 cycles of low time.
  localparam logic [7:0]  H_PER_LIM   = 8'h80;   // 128 cycles horizontal period.
  localparam logic [15:0] V_PER_MIN   = 16'h3C00; // 15360 cycles.
  localparam logic [15:0] V_PER_MAX   = 16'hBC00; // 48128 cycles.
  localparam logic [11:0] LPF_MAX     = 12'hFFF;  // Saturated line count, 4095 or more.

  // ==========================================================================
  // Free-running generator and reshaper counts.
  localparam logic [5:0]  FREE_H_PER  = 6'h23;    // 35 cycles.
  localparam logic [5:0]  FREE_H_LOW  = 6'h04;    // Low part of the pseudo line.
  localparam logic [15:0] FREE_V_PER  = 16'h7A80; // 31360 cycles.
  localparam logic [15:0] FREE_V_LOW  = 16'h0118; // Low part of the pseudo frame.
  localparam logic [2:0]  RESHAPE_N   = 3'h6;     // Horizontal falls ending vertical out.

  // Composite separation states.
  typedef enum logic [2:0] {
    SEP_PASS  = 3'b001,
    SEP_ARMED = 3'b010,
    SEP_VLOW  = 3'b100
  } vsp_sep_t;
endpackage

// >>> shared/vsp_flt_if.sv
// Filtered sync levels passed from the input filter to the processor core.
`timescale 1ns/1ps
interface vsp_flt_if;
  logic [2:0] lvl;
  modport src (output lvl);
  modport snk (input lvl);
endinterface

// >>> src/vsp_filter.sv
// Input synchroniser and glitch filter for the three sync inputs.
`timescale 1ns/1ps
module vsp_filter (
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  input  wire logic [2:0] i_raw,
  vsp_flt_if.src          flt
);
  // ==========================================================================
  // Per input: two synchroniser stages, one history stage and the output.
  logic [2:0] meta_r;
  logic [2:0] sync_r;
  logic [2:0] hist_r;
  logic [2:0] lvl_r;
  logic [2:0] lvl_nxt;

  for (genvar g = 0; g < 3; g++) begin : g_ch
    // A level is taken only after two equal samples, so pulses under one cycle drop.
    always_comb begin
      lvl_nxt[g] = (sync_r[g] == hist_r[g]) ? sync_r[g] : lvl_r[g];
    end

    // Registers the synchroniser chain and the filtered level.
    always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
        meta_r[g] <= vsp_pkg::FLT_RST;
        sync_r[g] <= vsp_pkg::FLT_RST;
        hist_r[g] <= vsp_pkg::FLT_RST;
        lvl_r[g]  <= vsp_pkg::FLT_RST;
      end else begin
        meta_r[g] <= i_raw[g];
        sync_r[g] <= meta_r[g];
        hist_r[g] <= sync_r[g];
        lvl_r[g]  <= lvl_nxt[g];
      end
    end
  end

  assign flt.lvl = lvl_r;
endmodule // vsp_filter

// >>> tb/vsp_sync_src.sv
// Behavioural sync source for the far side of the sync processor.
`timescale 1ns/1ps
module vsp_sync_src (
  input  wire logic        i_clk,
  input  wire logic        i_en,
  input  wire logic        i_h_inv,
  input  wire logic        i_v_inv,
  input  wire logic [15:0] i_h_per,
  input  wire logic [15:0] i_h_low,
  input  wire logic [15:0] i_v_per,
  input  wire logic [15:0] i_v_low,
  output logic             o_hsync,
  output logic             o_vsync
);
  logic [15:0] h_cnt = 16'h0000;
  logic [15:0] v_cnt = 16'h0000;
  // ==========================================================================
  // Line and frame counters step on the falling edge, away from sampling.
  // They wait at zero while disabled, so lines and frames start together.
  always @(negedge i_clk) begin
    if (!i_en) begin
      h_cnt <= 16'h0000;
      v_cnt <= 16'h0000;
    end else begin
      h_cnt <= (h_cnt + 16'h0001 >= i_h_per) ? 16'h0000 : h_cnt + 16'h0001;
      v_cnt <= (v_cnt + 16'h0001 >= i_v_per) ? 16'h0000 : v_cnt + 16'h0001;
    end
  end
  // Pulses open each period; inversion models a positive polarity source.
  assign o_hsync = i_en ? ((h_cnt < i_h_low) ^ ~i_h_inv) : 1'b1;
  assign o_vsync = i_en ? ((v_cnt < i_v_low) ^ ~i_v_inv) : 1'b1;
endmodule // vsp_sync_src

// >>> tb/video_sync_signal_processor_tb.sv
// Self-checking testbench for the sync processor.
`timescale 1ns/1ps
module video_sync_signal_processor_tb;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        set = 1'b0;
  logic        clr = 1'b0;
  logic        en = 1'b0;
  logic        h_inv = 1'b0;
  logic        v_inv = 1'b0;
  logic [15:0] v_per = 16'h0190;
  logic [15:0] v_low = 16'h0014;
  logic [15:0] h_per = 16'h0028;
  logic [15:0] h_low = 16'h0006;
  logic [1:0]  src_sel = 2'h0;
  logic        irq_en = 1'b0;
  logic [6:0]  irq_num = 7'h00;
  logic        hs, vs, ho, vo, hf, vf, sel, hp, vp, cs, irq;
  logic [11:0] lpf;
  int          err_total = 0;
  int          checked = 0;
  int          lo, per;
  // Clock of 40 ns period.
  always #20 clk = ~clk;
  // ==========================================================================
  // Far side and design.
  // Composite sync is the two far-side syncs merged.
  assign cs = hs & vs;
  vsp_sync_src src (.i_clk(clk), .i_en(en), .i_h_inv(h_inv), .i_v_inv(v_inv),
    .i_h_per(h_per), .i_h_low(h_low), .i_v_per(v_per), .i_v_low(v_low),
    .o_hsync(hs), .o_vsync(vs));
  vsp_sync_processor #(.FREE_V_PER(16'h0190), .V_PER_MIN(16'h00C8),
    .V_PER_MAX(16'h0258)) dut (.I_REF_CLK(clk), .I_NRST(nrst),
    .I_HSYNC(src_sel[0] ? cs : hs), .I_VSYNC(vs), .I_CSYNC(cs),
    .I_SYNC_SOURCE_SELECT(src_sel),
    .I_INSERT_DISABLE(1'b0), .I_PROCESSED_SYNC_SET(set), .I_PROCESSED_SYNC_CLR(clr),
    .I_LINE_IRQ_ENABLE(irq_en), .I_LINE_IRQ_NUMBER(irq_num), .O_HORIZ_SYNC_OUT(ho),
    .O_VERT_SYNC_OUT(vo), .O_HORIZ_ACTIVE_FLAG(hf), .O_VERT_ACTIVE_FLAG(vf),
    .O_PROCESSED_SYNC_SELECT(sel), .O_HORIZ_POL(hp), .O_VERT_POL(vp),
    .O_LINES_PER_FRAME(lpf), .O_LINE_IRQ(irq));
  // ==========================================================================
  // Checking helpers.
  task automatic chk_b(input string n, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic chk_i(input string n, input int l, input int h, input int g);
    checked++;
    if (g < l || g > h) begin
      err_total++;
      $display("[ERR] %s expected %0d..%0d seen %0d", n, l, h, g);
    end
  endtask
  function automatic logic pick(input int w);
    return (w == 0) ? ho : vo;
  endfunction
  // Measures low width and period of an output from one falling edge.
  task automatic meas(input int w, output int l, output int p);
    int n;
    n = 0;
    l = 0;
    while (pick(w) !== 1'b1 && n < 5000) begin @(negedge clk); n++; end
    while (pick(w) !== 1'b0 && n < 5000) begin @(negedge clk); n++; end
    while (pick(w) === 1'b0 && n < 5000) begin @(negedge clk); n++; l++; end
    p = l;
    while (pick(w) === 1'b1 && n < 5000) begin @(negedge clk); n++; p++; end
    if (n >= 5000) chk_i("edge wait", 0, 0, n);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Waits for both active flags, then requests the processed syncs.
  task automatic select_on();
    int n;
    n = 0;
    while ((hf !== 1'b1 || vf !== 1'b1) && n < 4000) begin cyc(1); n++; end
    set = 1'b1;
    cyc(1);
    set = 1'b0;
    cyc(2);
    chk_b("select", 1'b1, sel);
  endtask
  // ==========================================================================
  // Scenarios.
  // Reset values, looked at while reset is still held.
  task automatic t_reset();
    chk_b("h out", 1'b1, ho);
    chk_b("v out", 1'b1, vo);
    chk_b("select", 1'b0, sel);
    chk_b("h pol", 1'b0, hp);
    chk_b("v pol", 1'b0, vp);
  endtask
  task automatic t_free();
    meas(0, lo, per);
    chk_i("free h period", 35, 35, per);
    meas(1, lo, per);
    chk_i("free v period", 400, 400, per);
    set = 1'b1;
    cyc(1);
    set = 1'b0;
    cyc(2);
    chk_b("refused select", 1'b0, sel);
  endtask
  task automatic t_sep();
    en = 1'b1;
    select_on();
    meas(0, lo, per);
    chk_i("h low", 6, 6, lo);
    chk_i("h period", 40, 40, per);
    meas(1, lo, per);
    chk_i("v low", 240, 240, lo);
  endtask
  task automatic t_pos_h();
    h_inv = 1'b1;
    cyc(1000);
    chk_b("h pol", 1'b1, hp);
    select_on();
    meas(0, lo, per);
    chk_i("h low inverted", 6, 6, lo);
  endtask
  task automatic t_pos_v();
    v_per = 16'h04B0;
    v_low = 16'h0064;
    v_inv = 1'b1;
    cyc(4000);
    chk_b("v pol", 1'b1, vp);
    chk_b("select", 1'b0, sel);
  endtask
  task automatic t_off();
    v_per = 16'h0190;
    v_low = 16'h0014;
    v_inv = 1'b0;
    select_on();
    chk_b("v pol back", 1'b0, vp);
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
    cyc(3);
    chk_b("select cleared", 1'b0, sel);
    select_on();
    en = 1'b0;
    cyc(300);
    chk_b("h flag", 1'b0, hf);
    chk_b("select", 1'b0, sel);
    meas(0, lo, per);
    chk_i("pseudo h period", 35, 35, per);
  endtask
  // Composite sync on the horizontal pin, then on the composite pin.
  task automatic t_comp();
    int n;
    en = 1'b1;
    h_inv = 1'b0;
    src_sel = 2'h1;
    irq_en = 1'b1;
    irq_num = 7'h03;
    cyc(1200);
    select_on();
    meas(1, lo, per);
    chk_i("comp v low", 236, 240, lo);
    chk_i("comp v period", 400, 400, per);
    chk_i("lines per frame", 9, 9, lpf);
    n = 0;
    repeat (800) begin cyc(1); n += irq; end
    chk_i("line irq count", 2, 2, n);
    src_sel = 2'h2;
    cyc(1200);
    chk_b("csync select", 1'b1, sel);
  endtask
  // ==========================================================================
  // Verdict and end of run.
  task automatic end_sim();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Watchdog reckoned well beyond the expected run length.
  initial begin
    #(40 * 60000);
    err_total++;
    end_sim();
  end
  // Main sequence.
  initial begin
    cyc(4);
    t_reset();
    nrst = 1'b1;
    cyc(1);
    t_free();
    t_sep();
    t_pos_h();
    t_pos_v();
    t_off();
    t_comp();
    end_sim();
  end
endmodule // video_sync_signal_processor_tb
